// ==== verilog/rst_seq_pkg.sv ====
// Constants for the dual reset sequencer
package rst_seq_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_MHZ            = 250;
    localparam int unsigned PRIMARY_TIMEOUT_MS = 140;
    localparam int unsigned PRIMARY_TIMEOUT_CYC = PRIMARY_TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int unsigned SECONDARY_TIMEOUT_CYC = PRIMARY_TIMEOUT_CYC;
    localparam int unsigned FALL_DELAY_US      = 10;
    localparam int unsigned FALL_DELAY_CYC     = FALL_DELAY_US * CLK_MHZ;
    localparam int unsigned MR_PULSE_US        = 50;
    localparam int unsigned GLITCH_NS          = 100;
    localparam int unsigned GLITCH_CYC         = GLITCH_NS * CLK_MHZ / 1000;
    localparam int unsigned CNT_W              = 26;
    localparam int unsigned FILT_W             = 8;
    // Ramp: 600 nA into C up to 1.25 V; ramp step per cycle in ramp units
    localparam int unsigned RAMP_REF           = 1250;
    localparam int unsigned RAMP_W             = 40;
    // Delay-select detect: cycles counted before the pin level is sampled once
    localparam int unsigned DETECT_CYC         = 16;
endpackage : rst_seq_pkg

// ==== verilog/glitch_filter.sv ====
// Synchronizer plus low-going glitch filter for one comparator input
`timescale 1ns/1ps
`default_nettype none
module glitch_filter #(
    parameter int unsigned W   = 8,
    parameter int unsigned LEN = 25
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Raw level and filtered level
    input  wire logic raw,
    output logic      good_q
);
    logic         s1_q;
    logic         s2_q;
    logic [W-1:0] low_cnt_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // Dips shorter than LEN cycles are ignored; rising recovery is immediate
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_cnt_q <= '0;
            good_q    <= 1'b0;
        end else if (s2_q) begin
            low_cnt_q <= '0;
            good_q    <= 1'b1;
        end else if (low_cnt_q >= W'(LEN - 1)) begin
            good_q    <= 1'b0;
        end else begin
            low_cnt_q <= low_cnt_q + W'(1);
        end
    end
endmodule : glitch_filter
`default_nettype wire

// ==== verilog/dual_reset_sequencer.sv ====
// Sequenced dual reset supervisor: primary and secondary active-low resets
`timescale 1ns/1ps
`default_nettype none
module dual_reset_sequencer #(
    parameter int unsigned PRIMARY_TIMEOUT_CYC   = rst_seq_pkg::PRIMARY_TIMEOUT_CYC,
    parameter int unsigned SECONDARY_TIMEOUT_CYC = rst_seq_pkg::SECONDARY_TIMEOUT_CYC,
    parameter int unsigned FALL_DELAY_CYC        = rst_seq_pkg::FALL_DELAY_CYC,
    parameter int unsigned GLITCH_CYC            = rst_seq_pkg::GLITCH_CYC,
    parameter int unsigned RAMP_STEP             = 1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Comparator and pin inputs
    input  wire logic master_supply_ok,
    input  wire logic secondary_sense_input,
    input  wire logic delay_select_pin,
    input  wire logic manual_reset_n,
    // Reset outputs and delay mode flag
    output logic      primary_reset_n,
    output logic      secondary_reset_n,
    output logic      cap_mode
);
    localparam int unsigned CW = rst_seq_pkg::CNT_W;
    localparam int unsigned RW = rst_seq_pkg::RAMP_W;

    typedef enum logic [1:0] {
        SEC_HOLD  = 2'b00,
        SEC_WAIT  = 2'b01,
        SEC_TIME  = 2'b10,
        SEC_READY = 2'b11
    } sec_state_e;

    // ****************************************
    // Input conditioning
    // ****************************************
    logic supply_good;
    logic sense_good;
    logic mr_s1_q;
    logic mr_s2_q;
    logic sel_s1_q;
    logic sel_s2_q;

    glitch_filter #(.W(rst_seq_pkg::FILT_W), .LEN(GLITCH_CYC)) u_supply_filt (
        .clk    (clk),
        .rstn   (rstn),
        .raw    (master_supply_ok),
        .good_q (supply_good)
    );

    glitch_filter #(.W(rst_seq_pkg::FILT_W), .LEN(GLITCH_CYC)) u_sense_filt (
        .clk    (clk),
        .rstn   (rstn),
        .raw    (secondary_sense_input),
        .good_q (sense_good)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mr_s1_q  <= 1'b1;
            mr_s2_q  <= 1'b1;
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
        end else begin
            mr_s1_q  <= manual_reset_n;
            mr_s2_q  <= mr_s1_q;
            sel_s1_q <= delay_select_pin;
            sel_s2_q <= sel_s1_q;
        end
    end

    // ****************************************
    // Delay mode detection
    // ****************************************
    logic [4:0] det_cnt_q;
    logic       det_done_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            det_cnt_q  <= '0;
            det_done_q <= 1'b0;
            cap_mode   <= 1'b1;
        end else if (!det_done_q) begin
            if (det_cnt_q == 5'(rst_seq_pkg::DETECT_CYC - 1)) begin
                det_done_q <= 1'b1;
                cap_mode   <= !sel_s2_q;
            end else begin
                det_cnt_q <= det_cnt_q + 5'd1;
            end
        end
    end

    // ****************************************
    // Primary reset
    // ****************************************
    logic          pri_cond;
    logic          mr_active;
    logic [CW-1:0] pri_cnt_q;
    logic [CW-1:0] mr_lag_q;
    logic          pri_lagged_q;

    assign mr_active = !mr_s2_q;
    assign pri_cond  = !supply_good || mr_active;

    // manual reset reaches primary after a lag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mr_lag_q     <= '0;
            pri_lagged_q <= 1'b0;
        end else if (!mr_active) begin
            mr_lag_q     <= '0;
            pri_lagged_q <= 1'b0;
        end else if (mr_lag_q >= CW'(FALL_DELAY_CYC - 1)) begin
            pri_lagged_q <= 1'b1;
        end else begin
            mr_lag_q <= mr_lag_q + CW'(1);
        end
    end

    logic supply_fall_q;

    // supply drop reaches primary one cycle after secondary
    always_ff @(posedge clk) begin
        if (!rstn) begin
            supply_fall_q <= 1'b0;
        end else begin
            supply_fall_q <= !supply_good;
        end
    end

    // primary timeout restarts on each assert
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pri_cnt_q       <= '0;
            primary_reset_n <= 1'b0;
        end else if (pri_cond) begin
            pri_cnt_q <= '0;
            if (supply_fall_q || pri_lagged_q) begin
                primary_reset_n <= 1'b0;
            end
        end else if (!primary_reset_n) begin
            if (pri_cnt_q >= CW'(PRIMARY_TIMEOUT_CYC - 1)) begin
                primary_reset_n <= 1'b1;
            end else begin
                pri_cnt_q <= pri_cnt_q + CW'(1);
            end
        end
    end

    // ****************************************
    // Secondary reset
    // ****************************************
    sec_state_e    sec_q;
    logic [CW-1:0] sec_cnt_q;
    logic [RW-1:0] ramp_q;
    logic          sec_cond;
    logic          sec_done;

    assign sec_cond = !supply_good || !sense_good || mr_active;
    // fixed chain or ramp ends timeout
    assign sec_done = cap_mode ? (ramp_q >= RW'(rst_seq_pkg::RAMP_REF))
                               : (sec_cnt_q >= CW'(SECONDARY_TIMEOUT_CYC - 1));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sec_q             <= SEC_HOLD;
            sec_cnt_q         <= '0;
            ramp_q            <= '0;
            secondary_reset_n <= 1'b0;
        end else if (sec_cond) begin
            sec_q             <= SEC_HOLD;
            sec_cnt_q         <= '0;
            ramp_q            <= '0;
            secondary_reset_n <= 1'b0;
        end else begin
            case (sec_q)
                SEC_HOLD: begin
                    sec_q <= SEC_WAIT;
                end
                SEC_WAIT: begin
                    if (primary_reset_n && det_done_q) begin
                        sec_q <= SEC_TIME;
                    end
                end
                SEC_TIME: begin
                    if (sec_done) begin
                        sec_q             <= SEC_READY;
                        secondary_reset_n <= 1'b1;
                    end else if (cap_mode) begin
                        ramp_q <= ramp_q + RW'(RAMP_STEP);
                    end else begin
                        sec_cnt_q <= sec_cnt_q + CW'(1);
                    end
                end
                default: begin
                    secondary_reset_n <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_pri_low_rel;
        !primary_reset_n ##1 primary_reset_n;
    endsequence

    property p_pri_supply;
        @(posedge clk) disable iff (!rstn) (!supply_good ##1 !supply_good) |=> !primary_reset_n;
    endproperty
    a_pri_supply: assert property (p_pri_supply) else $error("primary not low on supply loss");

    property p_pri_rel_cause;
        @(posedge clk) disable iff (!rstn)
            s_pri_low_rel |-> $past(pri_cnt_q) >= CW'(PRIMARY_TIMEOUT_CYC - 1);
    endproperty
    a_pri_rel_cause: assert property (p_pri_rel_cause) else $error("primary released early");

    property p_sec_low;
        @(posedge clk) disable iff (!rstn) sec_cond |=> !secondary_reset_n;
    endproperty
    a_sec_low: assert property (p_sec_low) else $error("secondary not low");

    property p_sec_after_pri;
        @(posedge clk) disable iff (!rstn) $rose(secondary_reset_n) |-> primary_reset_n;
    endproperty
    a_sec_after_pri: assert property (p_sec_after_pri) else $error("secondary before primary");

    property p_sense_only;
        @(posedge clk) disable iff (!rstn)
            (primary_reset_n && supply_good && !mr_active && !sense_good) |=> primary_reset_n;
    endproperty
    a_sense_only: assert property (p_sense_only) else $error("sense moved primary");

    property p_order;
        @(posedge clk) disable iff (!rstn) $fell(primary_reset_n) |-> $past(!secondary_reset_n);
    endproperty
    a_order: assert property (p_order) else $error("primary fell first");

    property p_fixed_time;
        @(posedge clk) disable iff (!rstn)
            ($rose(secondary_reset_n) && !cap_mode) |-> $past(sec_cnt_q) >= CW'(SECONDARY_TIMEOUT_CYC - 1);
    endproperty
    a_fixed_time: assert property (p_fixed_time) else $error("fixed delay too short");

    property p_manual;
        @(posedge clk) disable iff (!rstn) mr_active |=> !secondary_reset_n;
    endproperty
    a_manual: assert property (p_manual) else $error("manual reset ignored");

    property p_ramp_time;
        @(posedge clk) disable iff (!rstn)
            ($rose(secondary_reset_n) && cap_mode) |-> $past(ramp_q) >= RW'(rst_seq_pkg::RAMP_REF);
    endproperty
    a_ramp_time: assert property (p_ramp_time) else $error("ramp ended early");

    // Cycles for which secondary has been low, for the lead check
    logic [CW-1:0] sec_low_cnt_q;

    always_ff @(posedge clk) begin
        if (!rstn || secondary_reset_n) begin
            sec_low_cnt_q <= '0;
        end else if (sec_low_cnt_q != '1) begin
            sec_low_cnt_q <= sec_low_cnt_q + CW'(1);
        end
    end

    property p_mr_lead;
        @(posedge clk) disable iff (!rstn)
            ($fell(primary_reset_n) && !$past(supply_fall_q))
                |-> sec_low_cnt_q >= CW'(FALL_DELAY_CYC);
    endproperty
    a_mr_lead: assert property (p_mr_lead) else $error("manual lead too short");

    property p_mode_hold;
        @(posedge clk) disable iff (!rstn) det_done_q |=> $stable(cap_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("delay mode changed");
endmodule : dual_reset_sequencer
`default_nettype wire

// ==== bench/reset_consumer.sv ====
// Behavioural model of the reset receivers and the manual reset switch
`timescale 1ns/1ps
`default_nettype none
module reset_consumer #(
    parameter int unsigned MR_HOLD = 12
) (
    // Clock
    input  wire logic clk,
    // Resets from the sequencer
    input  wire logic primary_reset_n,
    input  wire logic secondary_reset_n,
    // Push-button request and pin
    input  wire logic mr_req,
    output logic      manual_reset_n,
    // Sequencing fault seen
    output logic      order_err
);
    int unsigned hold_cnt;
    logic        req_q;
    initial begin
        manual_reset_n = 1'b1;
        order_err = 1'b0;
        hold_cnt = 0;
        req_q = 1'b0;
    end
    // Request taken on the rising edge so the pin moves on the next falling edge
    always @(posedge clk) begin
        req_q <= mr_req;
    end
    always @(negedge clk) begin
        if (req_q) begin
            manual_reset_n <= 1'b0;
            hold_cnt <= MR_HOLD;
        end else if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            manual_reset_n <= 1'b1;
        end
    end
    // Secondary side must never run while primary side is held
    always @(posedge clk) begin
        if (secondary_reset_n === 1'b1 && primary_reset_n === 1'b0) begin
            order_err <= 1'b1;
        end
    end
endmodule : reset_consumer
`default_nettype wire

// ==== bench/test_dual_reset_sequencer.sv ====
// Self-checking testbench for the dual reset sequencer
`timescale 1ns/1ps
`default_nettype none
module test_dual_reset_sequencer;
    localparam int unsigned PT = 40;
    localparam int unsigned ST = 50;
    localparam int unsigned FD = 5;
    localparam int unsigned GL = 3;
    localparam int unsigned RS = 125;
    localparam int unsigned CT = 1250 / RS;
    localparam int unsigned SL = 10;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic supply_ok = 1'b0;
    logic sense_ok = 1'b0;
    logic delay_pin = 1'b1;
    logic mr_req = 1'b0;
    logic manual_reset_n;
    logic primary_reset_n;
    logic secondary_reset_n;
    logic cap_mode;
    logic order_err;
    int   bad_count = 0;
    int   total_checks = 0;

    always #2 clk = ~clk;

    dual_reset_sequencer #(.PRIMARY_TIMEOUT_CYC(PT), .SECONDARY_TIMEOUT_CYC(ST),
        .FALL_DELAY_CYC(FD), .GLITCH_CYC(GL), .RAMP_STEP(RS)) dual_reset_sequencer_i (
        .clk(clk), .rstn(rstn), .master_supply_ok(supply_ok),
        .secondary_sense_input(sense_ok), .delay_select_pin(delay_pin),
        .manual_reset_n(manual_reset_n), .primary_reset_n(primary_reset_n),
        .secondary_reset_n(secondary_reset_n), .cap_mode(cap_mode));

    reset_consumer #(.MR_HOLD(12)) reset_consumer_i (
        .clk(clk), .primary_reset_n(primary_reset_n),
        .secondary_reset_n(secondary_reset_n), .mr_req(mr_req),
        .manual_reset_n(manual_reset_n), .order_err(order_err));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic check(input logic seen, input logic exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : check

    // Counts falling edges until the chosen reset reaches val
    task automatic wait_lvl(input bit sec, input logic val, output int unsigned n);
        n = 0;
        while (((sec ? secondary_reset_n : primary_reset_n) !== val) && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_lvl

    task automatic release_wait(input int unsigned sc);
        int unsigned n;
        wait_lvl(1'b0, 1'b1, n);
        check(n >= PT && n <= PT + SL, 1'b1, "primary timeout");
        check(secondary_reset_n, 1'b0, "secondary early");
        wait_lvl(1'b1, 1'b1, n);
        check(n >= sc && n <= sc + SL, 1'b1, "secondary timeout");
    endtask : release_wait

    task automatic do_reset(input logic pin);
        @(negedge clk);
        rstn = 1'b0;
        supply_ok = 1'b0;
        sense_ok = 1'b0;
        delay_pin = pin;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (24) @(negedge clk);
        check(cap_mode, ~pin, "delay mode");
        check(primary_reset_n | secondary_reset_n, 1'b0, "held low");
        supply_ok = 1'b1;
        sense_ok = 1'b1;
        release_wait(pin ? ST : CT);
    endtask : do_reset

    task automatic dips();
        supply_ok = 1'b0;
        repeat (GL - 1) @(negedge clk);
        supply_ok = 1'b1;
        sense_ok = 1'b0;
        repeat (GL - 1) @(negedge clk);
        sense_ok = 1'b1;
        repeat (20) @(negedge clk);
        check(primary_reset_n & secondary_reset_n, 1'b1, "dip ignored");
    endtask : dips

    task automatic sense_drop();
        int unsigned n;
        sense_ok = 1'b0;
        wait_lvl(1'b1, 1'b0, n);
        check(n <= GL + SL, 1'b1, "sense drop delay");
        repeat (PT + 10) @(negedge clk);
        check(primary_reset_n, 1'b1, "primary untouched");
        sense_ok = 1'b1;
        wait_lvl(1'b1, 1'b1, n);
        check(n >= ST && n <= ST + SL, 1'b1, "sense release");
    endtask : sense_drop

    task automatic supply_drop();
        int unsigned n;
        supply_ok = 1'b0;
        wait_lvl(1'b1, 1'b0, n);
        check(n <= GL + SL, 1'b1, "supply drop delay");
        check(primary_reset_n, 1'b1, "secondary first");
        wait_lvl(1'b0, 1'b0, n);
        check(n >= 1 && n <= 3, 1'b1, "primary follows");
        supply_ok = 1'b1;
        release_wait(ST);
    endtask : supply_drop

    task automatic manual();
        int unsigned n;
        mr_req = 1'b1;
        wait_lvl(1'b1, 1'b0, n);
        check(n <= SL, 1'b1, "manual secondary");
        check(primary_reset_n, 1'b1, "secondary leads");
        wait_lvl(1'b0, 1'b0, n);
        check(n >= FD - 1 && n <= FD + SL, 1'b1, "manual lag");
        repeat (PT + ST + 20) @(negedge clk);
        check(primary_reset_n | secondary_reset_n, 1'b0, "held by manual");
        mr_req = 1'b0;
        repeat (12) @(negedge clk);
        release_wait(ST);
    endtask : manual

    initial begin
        do_reset(1'b1);
        dips();
        sense_drop();
        supply_drop();
        manual();
        do_reset(1'b0);
        check(order_err, 1'b0, "release order");
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule : test_dual_reset_sequencer
`default_nettype wire
